// ==== rtl/fpgio_pkg.sv ====
// Package for the fan-pin general-purpose I/O block
// Assumes an 8-bit register port with byte addresses as printed
package fpgio_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_SELECT = 8'h7f;
  localparam logic [7:0] ADDR_SETUP  = 8'h80;
  localparam logic [7:0] ADDR_LEVEL  = 8'h81;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_SELECT = 8'h00;
  localparam logic [7:0] RST_SETUP  = 8'h00;
  localparam logic [7:0] RST_LEVEL  = 8'h00;

  // ****************************************
  // Field layout
  // ****************************************
  localparam int NUM_PINS      = 4;
  localparam int LEVEL_LSB     = 4;
  localparam int SEL_TOP       = 3;
  localparam int DIR_TOP       = 7;
  localparam int POL_TOP       = 6;
  localparam int SYNC_STAGES   = 2;

endpackage

// ==== rtl/fpgio_sync.sv ====
// Two-flop synchroniser for the pin input levels
// Assumes asynchronous pin levels and a single system clock
`timescale 1ns/10ps
module fpgio_sync (
  input  wire logic                           clk_i,
  input  wire logic                           rstn_i,
  input  wire logic                           en_i,
  input  wire logic [fpgio_pkg::NUM_PINS-1:0] d_i,
  output logic      [fpgio_pkg::NUM_PINS-1:0] q_o
);
  import fpgio_pkg::*;

  logic [NUM_PINS-1:0] s1_q, s1_d, s2_d;

  // ****************************************
  // Next values: first stage is read only by second
  // ****************************************
  always_comb begin
    s1_d = en_i ? d_i : s1_q;
    s2_d = en_i ? s1_q : q_o;
  end

  // Stages hold zero during reset
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s1_q <= '0;
      q_o  <= '0;
    end else begin
      s1_q <= s1_d;
      q_o  <= s2_d;
    end
  end

endmodule // fpgio_sync

// ==== rtl/fpgio_pinmux.sv ====
// Per-pin output mux: fan pulse or general-purpose drive
// Assumes all inputs are on the system clock
`timescale 1ns/10ps
module fpgio_pinmux (
  input  wire logic sel_i,
  input  wire logic dir_i,
  input  wire logic pol_i,
  input  wire logic asserted_i,
  input  wire logic fan_pwm_i,
  output logic      pin_d_o,
  output logic      oe_d_o
);

  // ****************************************
  // Next pin state
  // ****************************************
  always_comb begin
    if (!sel_i) begin
      pin_d_o = fan_pwm_i;
      oe_d_o  = 1'b1;
    end else if (dir_i) begin
      pin_d_o = asserted_i ~^ pol_i;
      oe_d_o  = 1'b1;
    end else begin
      pin_d_o = 1'b0;
      oe_d_o  = 1'b0;                // Input: release the pin
    end
  end

endmodule // fpgio_pinmux

// ==== rtl/fpgio_top.sv ====
// Fan-drive pins repurposed as general-purpose I/O, with three host registers
// Assumes a simple synchronous byte register port from the serial host logic
`timescale 1ns/10ps

// Contract
// - Select bit 3..0 turns fan pin 1..4 into a general pin.
// - Direction bit 1 means output, 0 input; bits 7,5,3,1 for pins 1-4.
// - Polarity bit 1 means active high; bits 6,4,2,0 for pins 1-4.
// - Output data comes from LSB of that channel's minimum duty register.
// - Level bit of an input pin ignores host writes.
// - Input pin level bit shows assertion judged against polarity.
// - Output level bit is writable and drives the pin to asserted level.
// - Level bits 7,6,5,4 belong to pins 4,3,2,1.
// - All three registers reset to zero; pins start as fan outputs (code releases the pads in reset until the first enabled edge).
module fpgio_top (
  input  wire logic                           clk_i,
  input  wire logic                           rstn_i,
  input  wire logic                           ce_i,
  input  wire logic                           reg_wr_i,
  input  wire logic                           reg_rd_i,
  input  wire logic [7:0]                     reg_addr_i,
  input  wire logic [7:0]                     reg_wdata_i,
  output logic      [7:0]                     reg_rdata_o,
  input  wire logic [fpgio_pkg::NUM_PINS-1:0] fan_pwm_i,
  input  wire logic [fpgio_pkg::NUM_PINS-1:0] min_duty_lsb_i,
  input  wire logic                           min_duty_wr_i,
  input  wire logic [fpgio_pkg::NUM_PINS-1:0] pin_i,
  output logic      [fpgio_pkg::NUM_PINS-1:0] pin_o,
  output logic      [fpgio_pkg::NUM_PINS-1:0] pin_oe_o
);
  import fpgio_pkg::*;

  // ****************************************
  // Register state
  // ****************************************
  logic [7:0]          select_q, select_d;
  logic [7:0]          setup_q, setup_d;
  logic [7:0]          level_q, level_d;
  logic [7:0]          rdata_d;
  logic [NUM_PINS-1:0] pin_sync;
  logic [NUM_PINS-1:0] sel_p, dir_p, pol_p, lvl_p;
  logic [NUM_PINS-1:0] pin_d, oe_d;

  // Pin-indexed views of the packed fields (pin k is index k-1, 0 = pin 1)
  genvar k;
  generate
    for (k = 0; k < NUM_PINS; k++) begin : g_pin
      assign sel_p[k] = select_q[SEL_TOP - k];
      assign dir_p[k] = setup_q[DIR_TOP - 2*k];
      assign pol_p[k] = setup_q[POL_TOP - 2*k];
      assign lvl_p[k] = level_q[LEVEL_LSB + k];
      fpgio_pinmux u_mux (
        .sel_i      (sel_p[k]),
        .dir_i      (dir_p[k]),
        .pol_i      (pol_p[k]),
        .asserted_i (lvl_p[k]),
        .fan_pwm_i  (fan_pwm_i[k]),
        .pin_d_o    (pin_d[k]),
        .oe_d_o     (oe_d[k])
      );
    end
  endgenerate

  // Pin levels arrive from the board asynchronously
  fpgio_sync u_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .en_i   (ce_i),
    .d_i    (pin_i),
    .q_o    (pin_sync)
  );

  // ****************************************
  // Register next values
  // ****************************************
  // Min duty LSB write lands in the level bit of an output pin so both
  // paths share one data flop; a host level write in the same cycle wins.
  always_comb begin
    select_d = select_q;
    setup_d  = setup_q;
    level_d  = level_q;
    rdata_d  = reg_rdata_o;
    if (reg_wr_i && reg_addr_i == ADDR_SELECT) begin
      select_d = reg_wdata_i;
    end
    if (reg_wr_i && reg_addr_i == ADDR_SETUP) begin
      setup_d = reg_wdata_i;
    end
    if (reg_wr_i && reg_addr_i == ADDR_LEVEL) begin
      level_d[LEVEL_LSB-1:0] = reg_wdata_i[LEVEL_LSB-1:0]; // Test bits stored only
    end
    for (int i = 0; i < NUM_PINS; i++) begin
      if (sel_p[i] && !dir_p[i]) begin
        level_d[LEVEL_LSB+i] = pin_sync[i] ~^ pol_p[i];
      end else if (sel_p[i]) begin
        if (min_duty_wr_i) begin
          level_d[LEVEL_LSB+i] = min_duty_lsb_i[i];
        end
        if (reg_wr_i && reg_addr_i == ADDR_LEVEL) begin
          level_d[LEVEL_LSB+i] = reg_wdata_i[LEVEL_LSB+i];
        end
      end else if (reg_wr_i && reg_addr_i == ADDR_LEVEL) begin
        level_d[LEVEL_LSB+i] = reg_wdata_i[LEVEL_LSB+i];   // Stored, no pin effect
      end
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        ADDR_SELECT: rdata_d = select_q;
        ADDR_SETUP:  rdata_d = setup_q;
        ADDR_LEVEL:  rdata_d = level_q;
        default:     rdata_d = 8'h00;
      endcase
    end
  end

  // Registers; all state frozen while the clock enable is low
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      select_q    <= RST_SELECT;
      setup_q     <= RST_SETUP;
      level_q     <= RST_LEVEL;
      reg_rdata_o <= 8'h00;
      pin_o       <= '0;
      pin_oe_o    <= '0;
    end else if (ce_i) begin
      select_q    <= select_d;
      setup_q     <= setup_d;
      level_q     <= level_d;
      reg_rdata_o <= rdata_d;
      pin_o       <= pin_d;
      pin_oe_o    <= oe_d;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  // Pads only leave their reset value at the first enabled edge after release
  unsel_fan_pass_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ($past(rstn_i) && $past(ce_i) && !$past(select_q[SEL_TOP]))
      |-> (pin_oe_o[0] && pin_o[0] == $past(fan_pwm_i[0])))
    else $error("unselected pin 1 not driving fan pulse");

  input_release_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ($past(ce_i) && $past(select_q[SEL_TOP-1]) && !$past(setup_q[DIR_TOP-2]))
      |-> !pin_oe_o[1])
    else $error("input pin 2 still driven");

  out_drive_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ($past(ce_i) && $past(select_q[SEL_TOP-2]) && $past(setup_q[DIR_TOP-4]))
      |-> (pin_oe_o[2] && pin_o[2] == ($past(level_q[LEVEL_LSB+2])
           ~^ $past(setup_q[POL_TOP-4]))))
    else $error("output pin 3 level wrong");

  in_level_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && sel_p[3] && !dir_p[3]) |=> (level_q[7] == $past(pin_sync[3] ~^ pol_p[3])))
    else $error("input pin 4 level flag wrong");

  in_readonly_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && sel_p[0] && !dir_p[0] && reg_wr_i && reg_addr_i == ADDR_LEVEL
     && reg_wdata_i[4] != (pin_sync[0] ~^ pol_p[0])) |=> (level_q[4] != $past(reg_wdata_i[4])))
    else $error("input level flag took a write");

  duty_lsb_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && sel_p[1] && dir_p[1] && min_duty_wr_i
     && !(reg_wr_i && reg_addr_i == ADDR_LEVEL)) |=> (level_q[5] == $past(min_duty_lsb_i[1])))
    else $error("duty lsb not taken");

  sel_write_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && reg_wr_i && reg_addr_i == ADDR_SELECT) |=> (select_q == $past(reg_wdata_i)))
    else $error("select register not written");

  reset_zero_a: assert property (@(posedge clk_i)
    !rstn_i |=> (select_q == 8'h00 && setup_q == 8'h00 && level_q == 8'h00))
    else $error("registers not zero after reset");

endmodule // fpgio_top

// ==== tb/fpgio_board.sv ====
// Board-side model of the four repurposed fan pins
// Assumes pad enables are high while the block drives the pad
`timescale 1ns/10ps
module fpgio_board (
  input  wire logic [3:0] drv_i,
  input  wire logic [3:0] drv_en_i,
  input  wire logic [3:0] lvl_i,
  output logic      [3:0] pad_o
);
  // Driven pad shows the block level, released pad shows the board level
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pad_o[i] = drv_en_i[i] ? drv_i[i] : lvl_i[i];
    end
  end
endmodule // fpgio_board

// ==== tb/tb.sv ====
// Self-checking bench for the fan-pin general-purpose I/O block
// Assumes the design package and the board model are compiled first
`timescale 1ns/10ps
module tb;
  import fpgio_pkg::*;
  logic       clk_i = 0, rstn_i = 0, ce_i = 1, reg_wr_i = 0, reg_rd_i = 0;
  logic       min_duty_wr_i = 0;
  logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o;
  logic [3:0] fan_pwm_i = 0, min_duty_lsb_i = 0, pin_i, pin_o, pin_oe_o, board_lvl = 0;
  logic [7:0] m_sel = 0, m_set = 0, m_lvl = 0;
  int         err_total = 0, n_compared = 0;

  // 20 MHz clock
  always #25 clk_i = ~clk_i;

  fpgio_top u_dut (
    .clk_i         (clk_i),
    .rstn_i        (rstn_i),
    .ce_i          (ce_i),
    .reg_wr_i      (reg_wr_i),
    .reg_rd_i      (reg_rd_i),
    .reg_addr_i    (reg_addr_i),
    .reg_wdata_i   (reg_wdata_i),
    .reg_rdata_o   (reg_rdata_o),
    .fan_pwm_i     (fan_pwm_i),
    .min_duty_lsb_i(min_duty_lsb_i),
    .min_duty_wr_i (min_duty_wr_i),
    .pin_i         (pin_i),
    .pin_o         (pin_o),
    .pin_oe_o      (pin_oe_o)
  );

  fpgio_board u_board (
    .drv_i   (pin_o),
    .drv_en_i(pin_oe_o),
    .lvl_i   (board_lvl),
    .pad_o   (pin_i)
  );

  // ****************************************
  // Model and shared tasks
  // ****************************************
  // Level register as the model sees it; only valid once the pads settle
  function automatic logic [7:0] lvl_exp();
    logic [7:0] v;
    v = m_lvl;
    for (int i = 0; i < 4; i++) begin
      if (m_sel[3-i] && !m_set[7-2*i]) v[4+i] = ~(board_lvl[i] ^ m_set[6-2*i]);
    end
    return v;
  endfunction

  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (e !== g) begin
      $display("MISMATCH %s expected %h seen %h", what, e, g);
      err_total++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] ro;
    @(negedge clk_i);
    reg_wr_i = 1;
    reg_addr_i = a;
    reg_wdata_i = d;
    m_lvl = lvl_exp();
    ro = 0;
    for (int i = 0; i < 4; i++) ro[4+i] = m_sel[3-i] && !m_set[7-2*i];
    if (a == ADDR_SELECT) m_sel = d;
    if (a == ADDR_SETUP) m_set = d;
    if (a == ADDR_LEVEL) m_lvl = (d & ~ro) | (m_lvl & ro);
    @(negedge clk_i);
    reg_wr_i = 0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_i);
    reg_rd_i = 1;
    reg_addr_i = a;
    @(negedge clk_i);
    reg_rd_i = 0;
    chk("reg_rdata_o", e, reg_rdata_o);
  endtask

  // Duty LSB update lands only on selected output pins
  task automatic duty(input logic [3:0] b);
    @(negedge clk_i);
    min_duty_wr_i = 1;
    min_duty_lsb_i = b;
    for (int i = 0; i < 4; i++) if (m_sel[3-i] && m_set[7-2*i]) m_lvl[4+i] = b[i];
    @(negedge clk_i);
    min_duty_wr_i = 0;
  endtask

  // Pad check each cycle; fan pulse is fresh random every cycle
  task automatic pins(input int n);
    logic [3:0] eo, ee;
    repeat (n) begin
      @(negedge clk_i);
      for (int i = 0; i < 4; i++) begin
        ee[i] = !m_sel[3-i] || m_set[7-2*i];
        eo[i] = m_sel[3-i] ? ~(m_lvl[4+i] ^ m_set[6-2*i]) : fan_pwm_i[i];
      end
      chk("pin_oe_o", 8'(ee), 8'(pin_oe_o));
      chk("pin_o", 8'(eo & ee), 8'(pin_o & ee));
      fan_pwm_i = 4'($urandom);
    end
  endtask

  task automatic final_report();
    if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(41));
    repeat (6) @(negedge clk_i);
    rstn_i = 1;
    rd(ADDR_SELECT, RST_SELECT);
    rd(ADDR_SETUP, RST_SETUP);
    rd(ADDR_LEVEL, RST_LEVEL);
    rd(8'h82, 8'h00);
    pins(4);
    for (int k = 0; k < 24; k++) begin
      // Deselect first so stale pad status never leaks into the model
      wr(ADDR_SELECT, 8'h00);
      wr(ADDR_SETUP, 8'($urandom));
      wr(ADDR_LEVEL, 8'($urandom) & 8'hf0);
      board_lvl = 4'($urandom);
      wr(ADDR_SELECT, (k < 16) ? 8'(k) : 8'($urandom) & 8'h0f);
      pins(4);
      rd(ADDR_SETUP, m_set);
      rd(ADDR_SELECT, m_sel);
      rd(ADDR_LEVEL, lvl_exp());
      wr(ADDR_LEVEL, 8'($urandom) & 8'hf0);
      pins(2);
      rd(ADDR_LEVEL, lvl_exp());
      duty(4'($urandom));
      pins(2);
      rd(ADDR_LEVEL, lvl_exp());
    end
    // Clock enable low: a write in that cycle must not land
    @(negedge clk_i);
    ce_i = 0;
    reg_wr_i = 1;
    reg_addr_i = ADDR_SELECT;
    reg_wdata_i = ~m_sel & 8'h0f;
    @(negedge clk_i);
    reg_wr_i = 0;
    ce_i = 1;
    rd(ADDR_SELECT, m_sel);
    final_report();
  end
endmodule // tb
